/* File: hdl/parallel_program_loader.v */
// Parallel programming front end: mode entry, command/address/data loads,
// chip erase with ready/busy, and the flash page buffer.
// Assumes all pins are asynchronous to clk_i; the memory array sits outside.
`include "ppl_defines.vh"

module parallel_program_loader #(
  parameter ERASE_CYCLES = `ERASE_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Programming pins
  input  wire        reset_pin_low_i,
  input  wire        prog_voltage_i,
  input  wire        crystal_input_strobe_i,
  input  wire        page_load_strobe_i,
  input  wire        action_select_hi_i,
  input  wire        action_select_lo_i,
  input  wire        byte_select_one_i,
  input  wire        byte_select_two_i,
  input  wire        write_n_i,
  input  wire        output_enable_n_i,
  input  wire [7:0]  data_i,
  output reg  [7:0]  data_o,
  output reg         data_oe_o,
  output reg         ready_busy_out_o,
  // Fuse and memory side
  input  wire        eeprom_keep_fuse_i,
  input  wire [7:0]  read_data_i,
  input  wire        page_ready_i,
  output reg         prog_mode_o,
  output reg  [7:0]  command_o,
  output reg  [15:0] address_o,
  output reg         erase_flash_o,
  output reg         erase_eeprom_o,
  output reg         erase_locks_o,
  output reg  [6:0]  page_index_o,
  output reg  [5:0]  word_in_page_index_o,
  output reg  [8:0]  eeprom_byte_address_o,
  output reg         page_valid_o,
  output reg  [15:0] page_word_o,
  output reg  [5:0]  page_word_index_o,
  output reg         cmd_wr_fuse_o,
  output reg         cmd_wr_lock_o,
  output reg         cmd_wr_eeprom_o,
  output reg         cmd_rd_sig_o,
  output reg         cmd_rd_fuse_o,
  output reg         cmd_rd_flash_o,
  output reg         cmd_rd_eeprom_o
);

  localparam NPIN = 19;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire [NPIN-1:0] pin_raw = {data_i, output_enable_n_i, write_n_i, byte_select_two_i,
                             byte_select_one_i, action_select_lo_i, action_select_hi_i,
                             page_load_strobe_i, crystal_input_strobe_i, prog_voltage_i,
                             reset_pin_low_i, eeprom_keep_fuse_i};
  reg  [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q  <= {NPIN{1'b0}};
      s2_q  <= {NPIN{1'b0}};
      s3_q  <= {NPIN{1'b0}};
      pin_q <= {NPIN{1'b0}};
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & pin_q);
    end
  end

  wire       keep_ee = pin_q[0];
  wire       rst_low = pin_q[1];
  wire       hv      = pin_q[2];
  wire       xtal    = pin_q[3];
  wire [3:0] entry   = pin_q[7:4];
  wire [1:0] action  = {pin_q[5], pin_q[6]};
  wire       bs1     = pin_q[7];
  wire       wr_n    = pin_q[9];
  wire       oe_n    = pin_q[10];
  wire [7:0] dbus    = pin_q[18:11];

  reg xtal_prev_q, wr_prev_q, hv_prev_q;
  wire xtal_rise = xtal & ~xtal_prev_q;
  wire wr_fall   = ~wr_n & wr_prev_q;
  wire hv_rise   = hv & ~hv_prev_q;

  // ----------------------------------------------------------------------
  // Mode entry
  // ----------------------------------------------------------------------
  localparam E_IDLE = 2'h0;
  localparam E_ARM  = 2'h1;
  localparam E_HOLD = 2'h2;
  localparam E_PROG = 2'h3;
  reg [1:0] est_q;
  reg [2:0] toggles_q;
  reg [7:0] hold_q;
  reg [3:0] entry_ref_q;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      est_q       <= E_IDLE;
      toggles_q   <= 3'h0;
      hold_q      <= 8'h00;
      entry_ref_q <= 4'h0;
      prog_mode_o <= 1'b0;
      xtal_prev_q <= 1'b0;
      wr_prev_q   <= 1'b0;
      hv_prev_q   <= 1'b0;
    end else begin
      xtal_prev_q <= xtal;
      wr_prev_q   <= wr_n;
      hv_prev_q   <= hv;
      if (!hv && est_q != E_ARM) begin
        est_q       <= E_IDLE;
        prog_mode_o <= 1'b0;
      end
      case (est_q)
        E_IDLE: begin
          if (!rst_low)
            toggles_q <= 3'h0;
          else if (xtal_rise && toggles_q != `ENTRY_TOGGLES)
            toggles_q <= toggles_q + 3'h1;
          if (toggles_q == `ENTRY_TOGGLES)
            est_q <= E_ARM;
        end
        E_ARM: begin
          if (hv_rise && entry == 4'h0) begin
            est_q       <= E_HOLD;
            hold_q      <= 8'h00;
            entry_ref_q <= entry;
          end else if (hv_rise) begin
            est_q     <= E_IDLE;
            toggles_q <= 3'h0;
          end
        end
        E_HOLD: begin
          if (entry != entry_ref_q) begin
            est_q     <= E_IDLE;
            toggles_q <= 3'h0;
          end else if (hold_q == `ENTRY_HOLD_CYC - 1) begin
            est_q       <= E_PROG;
            prog_mode_o <= 1'b1;
          end else
            hold_q <= hold_q + 8'h01;
        end
        E_PROG: ;
        default: est_q <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Loads, erase and page buffer
  // ----------------------------------------------------------------------
  localparam ERASE_W = 32;
  reg [ERASE_W-1:0] erase_cnt_q;
  reg [1:0]         erase_ph_q;
  reg [7:0]         data_lo_q;
  reg [15:0]        buf_q [0:`FLASH_PAGE_WORDS-1];
  reg [1:0]         slot_cnt_q;
  reg [15:0]        slot_q [0:1];
  reg [5:0]         slot_idx_q [0:1];
  reg               slot_rd_q;
  wire              buf_ready = (slot_cnt_q != 2'h2);
  wire              loading = prog_mode_o && xtal_rise && ready_busy_out_o;
  wire [5:0]        word_idx = address_o[`FLASH_WORD_MSB:0];
  // A high flash data byte pushes one word; a full buffer refuses every load.
  wire              push = loading && buf_ready && action == `ACT_LOAD_DATA && bs1 &&
                           command_o == `CMD_WR_FLASH;
  wire              pop  = slot_cnt_q != 2'h0 && page_ready_i;
  integer i;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      command_o        <= 8'h00;
      address_o        <= 16'h0000;
      data_lo_q        <= 8'h00;
      ready_busy_out_o <= 1'b1;
      erase_cnt_q      <= {ERASE_W{1'b0}};
      erase_ph_q       <= 2'h0;
      erase_flash_o    <= 1'b0;
      erase_eeprom_o   <= 1'b0;
      erase_locks_o    <= 1'b0;
      slot_cnt_q       <= 2'h0;
      slot_rd_q        <= 1'b0;
      page_valid_o     <= 1'b0;
      page_word_o      <= 16'h0000;
      page_word_index_o <= 6'h00;
      for (i = 0; i < 2; i = i + 1) begin
        slot_q[i]     <= 16'h0000;
        slot_idx_q[i] <= 6'h00;
      end
      for (i = 0; i < `FLASH_PAGE_WORDS; i = i + 1)
        buf_q[i] <= 16'h0000;
    end else begin
      if (loading && buf_ready) begin
        case (action)
          `ACT_LOAD_ADDR: begin
            if (bs1) address_o[15:8] <= dbus;
            else     address_o[7:0]  <= dbus;
          end
          `ACT_LOAD_DATA: begin
            if (!bs1) data_lo_q <= dbus;
          end
          `ACT_LOAD_CMD: command_o <= dbus;
          default: ;
        endcase
      end
      // Two-entry buffer between loads and the page buffer or consumer.
      page_valid_o <= 1'b0;
      if (pop) begin
        buf_q[slot_idx_q[slot_rd_q]] <= slot_q[slot_rd_q];
        page_word_o       <= slot_q[slot_rd_q];
        page_word_index_o <= slot_idx_q[slot_rd_q];
        page_valid_o      <= 1'b1;
        slot_rd_q         <= ~slot_rd_q;
      end
      if (push) begin
        slot_q[slot_rd_q ^ slot_cnt_q[0]]     <= {dbus, data_lo_q};
        slot_idx_q[slot_rd_q ^ slot_cnt_q[0]] <= word_idx;
      end
      slot_cnt_q <= slot_cnt_q + {1'b0, push} - {1'b0, pop};
      // Chip erase: flash and, unless keep_ee, EEPROM first, locks only afterwards.
      case (erase_ph_q)
        2'h0: if (prog_mode_o && wr_fall && command_o == `CMD_CHIP_ERASE) begin
          erase_ph_q       <= 2'h1;
          erase_cnt_q      <= {ERASE_W{1'b0}};
          ready_busy_out_o <= 1'b0;
          erase_flash_o    <= 1'b1;
          erase_eeprom_o   <= ~keep_ee;
        end
        2'h1: if (erase_cnt_q == ERASE_CYCLES - 1) begin
          erase_ph_q    <= 2'h2;
          erase_flash_o <= 1'b0;
          erase_eeprom_o <= 1'b0;
          erase_locks_o <= 1'b1;
        end else
          erase_cnt_q <= erase_cnt_q + 1'b1;
        2'h2: begin
          erase_ph_q       <= 2'h0;
          erase_locks_o    <= 1'b0;
          ready_busy_out_o <= 1'b1;
        end
        default: erase_ph_q <= 2'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Decode, geometry and read bus
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      {cmd_wr_fuse_o, cmd_wr_lock_o, cmd_wr_eeprom_o, cmd_rd_sig_o} <= 4'h0;
      {cmd_rd_fuse_o, cmd_rd_flash_o, cmd_rd_eeprom_o}             <= 3'h0;
      page_index_o          <= 7'h00;
      word_in_page_index_o  <= 6'h00;
      eeprom_byte_address_o <= 9'h000;
      data_o                <= 8'h00;
      data_oe_o             <= 1'b0;
    end else begin
      cmd_wr_fuse_o   <= command_o == `CMD_WR_FUSE;
      cmd_wr_lock_o   <= command_o == `CMD_WR_LOCK;
      cmd_wr_eeprom_o <= command_o == `CMD_WR_EEPROM;
      cmd_rd_sig_o    <= command_o == `CMD_RD_SIG;
      cmd_rd_fuse_o   <= command_o == `CMD_RD_FUSE;
      cmd_rd_flash_o  <= command_o == `CMD_RD_FLASH;
      cmd_rd_eeprom_o <= command_o == `CMD_RD_EEPROM;
      page_index_o          <= address_o[`FLASH_PAGE_MSB:`FLASH_PAGE_LSB];
      word_in_page_index_o  <= address_o[`FLASH_WORD_MSB:0];
      eeprom_byte_address_o <= address_o[`EE_PAGE_MSB:0];
      data_oe_o             <= prog_mode_o && !oe_n;
      data_o                <= read_data_i;
    end
  end

endmodule

/* File: hdl/ppl_defines.vh */
// Constants of the parallel program loader: pin codes, command bytes,
// memory geometry and entry timing counts.
// Assumes inclusion by bare name from the loader's design file.
`ifndef PPL_DEFINES_VH
`define PPL_DEFINES_VH

// ----------------------------------------------------------------------
// Action select codes {hi, lo}
// ----------------------------------------------------------------------
`define ACT_LOAD_ADDR   2'h0
`define ACT_LOAD_DATA   2'h1
`define ACT_LOAD_CMD    2'h2
`define ACT_IDLE        2'h3

// ----------------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------------
`define CMD_CHIP_ERASE  8'h80
`define CMD_WR_FUSE     8'h40
`define CMD_WR_LOCK     8'h20
`define CMD_WR_FLASH    8'h10
`define CMD_WR_EEPROM   8'h11
`define CMD_RD_SIG      8'h08
`define CMD_RD_FUSE     8'h04
`define CMD_RD_FLASH    8'h02
`define CMD_RD_EEPROM   8'h03

// ----------------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------------
`define FLASH_WORD_MSB  5
`define FLASH_PAGE_LSB  6
`define FLASH_PAGE_MSB  12
`define EE_BYTE_MSB     1
`define EE_PAGE_LSB     2
`define EE_PAGE_MSB     8
`define FLASH_PAGE_WORDS 64

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   5
`define ENTRY_HOLD_NS   100
`define ENTRY_HOLD_CYC  ((`ENTRY_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENTRY_TOGGLES   6
`define ERASE_CYC       1000

`endif

/* File: testbench/ppl_chk.sv */
// Assertion checker for the parallel program loader, watching its ports.
// Assumes one clock and the synchronous active-high reset.
`include "ppl_defines.vh"
module ppl_chk #(
  parameter ERASE_CYCLES = 10
) (
  // Clock and reset
  input wire        clk_i,
  input wire        sys_rst_i,
  // Observed ports
  input wire        eeprom_keep_fuse_i,
  input wire        ready_busy_out_o,
  input wire        prog_mode_o,
  input wire        data_oe_o,
  input wire [7:0]  command_o,
  input wire [15:0] address_o,
  input wire        erase_flash_o,
  input wire        erase_eeprom_o,
  input wire        erase_locks_o,
  input wire [6:0]  page_index_o,
  input wire [5:0]  word_in_page_index_o,
  input wire [8:0]  eeprom_byte_address_o,
  input wire        cmd_rd_flash_o,
  input wire        cmd_rd_eeprom_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] cnt_q;
  // Length of the current erase run.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !erase_flash_o) cnt_q <= 16'h0;
    else cnt_q <= cnt_q + 16'h1;
  end
  property p_rst; $fell(sys_rst_i) |-> ready_busy_out_o && !prog_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_busy; erase_flash_o |-> !ready_busy_out_o; endproperty
  a_busy: assert property (p_busy) else $error("ready during erase");
  property p_len;
    $fell(erase_flash_o) && !$past(sys_rst_i) |-> cnt_q == ERASE_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("erase length wrong");
  property p_lock; $rose(erase_locks_o) |-> $past(erase_flash_o) && !erase_flash_o; endproperty
  a_lock: assert property (p_lock) else $error("locks cleared early");
  property p_lkend; erase_locks_o |=> !erase_locks_o ##[0:2] ready_busy_out_o; endproperty
  a_lkend: assert property (p_lkend) else $error("erase end wrong");
  property p_ee; erase_eeprom_o |-> erase_flash_o && !eeprom_keep_fuse_i; endproperty
  a_ee: assert property (p_ee) else $error("eeprom erased wrongly");
  property p_pg;
    $changed(address_o) |=> page_index_o == address_o[12:6]
      && word_in_page_index_o == address_o[5:0];
  endproperty
  a_pg: assert property (p_pg) else $error("flash geometry wrong");
  property p_eea; $changed(address_o) |=> eeprom_byte_address_o == address_o[8:0]; endproperty
  a_eea: assert property (p_eea) else $error("eeprom address wrong");
  property p_dec;
    $changed(command_o) |=> cmd_rd_flash_o == (command_o == `CMD_RD_FLASH)
      && cmd_rd_eeprom_o == (command_o == `CMD_RD_EEPROM);
  endproperty
  a_dec: assert property (p_dec) else $error("command decode wrong");
  property p_oe; data_oe_o |-> $past(prog_mode_o); endproperty
  a_oe: assert property (p_oe) else $error("bus driven outside mode");
  property p_hold; !ready_busy_out_o |=> $stable(command_o) && $stable(address_o); endproperty
  a_hold: assert property (p_hold) else $error("load taken while busy");
endmodule

bind parallel_program_loader ppl_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .clk_i, .sys_rst_i, .eeprom_keep_fuse_i, .ready_busy_out_o, .prog_mode_o, .data_oe_o,
  .command_o, .address_o, .erase_flash_o, .erase_eeprom_o, .erase_locks_o, .page_index_o,
  .word_in_page_index_o, .eeprom_byte_address_o, .cmd_rd_flash_o, .cmd_rd_eeprom_o);

/* File: testbench/ppl_programmer.sv */
// Model of the external parallel programmer driving the loader's pins.
// Assumes the loader needs a few clk_i cycles to see each pin change.
`include "ppl_defines.vh"
module ppl_programmer (
  // Clock
  input  wire        clk_i,
  // Pins towards the loader
  output logic       rst_low_o,
  output logic       vpp_o,
  output logic       stb_o,
  output logic       pgl_o,
  output logic       act_hi_o,
  output logic       act_lo_o,
  output logic       bs1_o,
  output logic       wr_n_o,
  output logic       oe_n_o,
  output logic [7:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rst_low_o, vpp_o, stb_o, pgl_o, act_hi_o, act_lo_o, bs1_o} = 7'h00;
    {wr_n_o, oe_n_o} = 2'h3;
    dat_o = 8'h00;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Pins settle 8 cycles before each strobe rise and hold 8 cycles after it.
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
    {act_hi_o, act_lo_o} = act;
    bs1_o = bs1;
    dat_o = d;
    pgl_o = 1'($urandom);
    wait_n(8);
    stb_o = 1'b1;
    wait_n(8);
    stb_o = 1'b0;
    dat_o = ~d;
    {act_hi_o, act_lo_o} = `ACT_IDLE;
    wait_n(8);
  endtask
  task automatic enter(input logic bad);
    vpp_o = 1'b0;
    rst_low_o = 1'b1;
    repeat (6) begin
      stb_o = 1'b1;
      wait_n(4);
      stb_o = 1'b0;
      wait_n(4);
    end
    {pgl_o, act_hi_o, act_lo_o, bs1_o} = 4'h0;
    wait_n(24);
    rst_low_o = 1'b0;
    vpp_o = 1'b1;
    if (bad) begin
      wait_n(6);
      bs1_o = 1'b1;
      wait_n(4);
      bs1_o = 1'b0;
    end
  endtask
  task automatic oe(input logic v);
    oe_n_o = v;
  endtask
  task automatic erase();
    load(`ACT_LOAD_CMD, 1'b0, `CMD_CHIP_ERASE);
    wr_n_o = 1'b0;
    wait_n(4);
    wr_n_o = 1'b1;
  endtask
endmodule

/* File: testbench/tb_parallel_program_loader.sv */
// Self-checking testbench of the parallel program loader.
// Assumes the loader, its header and the programmer model are compiled first.
`include "ppl_defines.vh"
module tb_parallel_program_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reset_pin_low_i, prog_voltage_i, crystal_input_strobe_i, page_load_strobe_i;
  logic action_select_hi_i, action_select_lo_i, byte_select_one_i, write_n_i;
  logic output_enable_n_i, byte_select_two_i, eeprom_keep_fuse_i, page_ready_i;
  logic [7:0] data_i, data_o, read_data_i, command_o;
  logic data_oe_o, ready_busy_out_o, prog_mode_o, erase_flash_o, erase_eeprom_o;
  logic erase_locks_o, page_valid_o, cmd_wr_fuse_o, cmd_wr_lock_o, cmd_wr_eeprom_o;
  logic cmd_rd_sig_o, cmd_rd_fuse_o, cmd_rd_flash_o, cmd_rd_eeprom_o;
  logic [5:0] idxs [$];
  int ee_cyc = 0;
  logic [15:0] address_o, page_word_o, a;
  logic [15:0] w [4];
  logic [15:0] words [$];
  logic [6:0] page_index_o;
  logic [5:0] word_in_page_index_o, page_word_index_o;
  logic [8:0] eeprom_byte_address_o;
  logic [7:0] cmds [9] = '{`CMD_CHIP_ERASE, `CMD_WR_FUSE, `CMD_WR_LOCK, `CMD_WR_FLASH,
    `CMD_WR_EEPROM, `CMD_RD_SIG, `CMD_RD_FUSE, `CMD_RD_FLASH, `CMD_RD_EEPROM};
  int error_cnt = 0;
  int n_compared = 0;
  int n, ee0;
  parallel_program_loader #(.ERASE_CYCLES(10)) u_dut (.clk_i, .sys_rst_i, .reset_pin_low_i,
    .prog_voltage_i, .crystal_input_strobe_i, .page_load_strobe_i, .action_select_hi_i,
    .action_select_lo_i, .byte_select_one_i, .byte_select_two_i, .write_n_i,
    .output_enable_n_i, .data_i, .data_o, .data_oe_o, .ready_busy_out_o, .eeprom_keep_fuse_i,
    .read_data_i, .page_ready_i, .prog_mode_o, .command_o, .address_o, .erase_flash_o,
    .erase_eeprom_o, .erase_locks_o, .page_index_o, .word_in_page_index_o,
    .eeprom_byte_address_o, .page_valid_o, .page_word_o, .page_word_index_o, .cmd_wr_fuse_o,
    .cmd_wr_lock_o, .cmd_wr_eeprom_o, .cmd_rd_sig_o, .cmd_rd_fuse_o, .cmd_rd_flash_o,
    .cmd_rd_eeprom_o);
  ppl_programmer u_prg (.clk_i, .rst_low_o(reset_pin_low_i), .vpp_o(prog_voltage_i),
    .stb_o(crystal_input_strobe_i), .pgl_o(page_load_strobe_i), .act_hi_o(action_select_hi_i),
    .act_lo_o(action_select_lo_i), .bs1_o(byte_select_one_i), .wr_n_o(write_n_i),
    .oe_n_o(output_enable_n_i), .dat_o(data_i));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (page_valid_o) words.push_back(page_word_o);
    if (page_valid_o) idxs.push_back(page_word_index_o);
    if (erase_eeprom_o) ee_cyc <= ee_cyc + 1;
  end
  function automatic logic [6:0] dec(input logic [7:0] c);
    return {c == `CMD_WR_FUSE, c == `CMD_WR_LOCK, c == `CMD_WR_EEPROM, c == `CMD_RD_SIG,
      c == `CMD_RD_FUSE, c == `CMD_RD_FLASH, c == `CMD_RD_EEPROM};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The tests take about 1100 cycles; the watchdog allows 10000.
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
  initial begin
    {byte_select_two_i, eeprom_keep_fuse_i, page_ready_i} = 3'h0;
    read_data_i = 8'h00;
    void'($urandom(172));
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(16'(ready_busy_out_o), 16'h1);
    u_prg.enter(1'b1);
    u_prg.wait_n(40);
    chk(16'(prog_mode_o), 16'h0);
    u_prg.enter(1'b0);
    u_prg.wait_n(10);
    chk(16'(prog_mode_o), 16'h0);
    u_prg.wait_n(30);
    chk(16'(prog_mode_o), 16'h1);
    $display("entry test done");
    foreach (cmds[i]) begin
      u_prg.load(`ACT_LOAD_CMD, 1'b0, cmds[i]);
      chk(16'(command_o), 16'(cmds[i]));
      chk(16'({cmd_wr_fuse_o, cmd_wr_lock_o, cmd_wr_eeprom_o, cmd_rd_sig_o, cmd_rd_fuse_o,
        cmd_rd_flash_o, cmd_rd_eeprom_o}), 16'(dec(cmds[i])));
      chk(16'(ready_busy_out_o), 16'h1);
    end
    u_prg.load(`ACT_IDLE, 1'b0, 8'h5a);
    chk(16'(command_o), 16'(`CMD_RD_EEPROM));
    $display("command test done");
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'h1fff : 16'($urandom);
      u_prg.load(`ACT_LOAD_ADDR, 1'b0, a[7:0]);
      u_prg.load(`ACT_LOAD_ADDR, 1'b1, a[15:8]);
      chk(address_o, a);
      chk(16'(page_index_o), 16'(a[12:6]));
      chk(16'(word_in_page_index_o), 16'(a[5:0]));
      chk(16'(eeprom_byte_address_o), 16'(a[8:0]));
      a[7:0] = ~a[7:0];
      u_prg.load(`ACT_LOAD_ADDR, 1'b0, a[7:0]);
      chk(address_o, a);
      chk(16'(command_o), 16'(`CMD_RD_EEPROM));
    end
    $display("address test done");
    for (int k = 0; k < 2; k++) begin
      eeprom_keep_fuse_i = k[0];
      ee0 = ee_cyc;
      u_prg.erase();
      u_prg.wait_n(4);
      chk(16'(ready_busy_out_o), 16'h0);
      n = 0;
      while (ready_busy_out_o !== 1'b1 && n < 200) begin
        u_prg.wait_n(1);
        n++;
      end
      chk(16'(ready_busy_out_o), 16'h1);
      chk(16'(ee_cyc != ee0), 16'(!k[0]));
    end
    $display("erase test done");
    u_prg.load(`ACT_LOAD_CMD, 1'b0, `CMD_WR_FLASH);
    for (int i = 0; i < 4; i++) begin
      w[i] = (i == 0) ? 16'hffff : 16'($urandom);
      byte_select_two_i = 1'($urandom);
      if (i == 3) page_ready_i = 1'b1;
      u_prg.load(`ACT_LOAD_DATA, 1'b0, w[i][7:0]);
      u_prg.load(`ACT_LOAD_DATA, 1'b1, w[i][15:8]);
      if (i == 2) chk(16'(words.size()), 16'h0);
    end
    chk(16'(words.size()), 16'h3);
    chk(words[0], w[0]);
    chk(words[1], w[1]);
    chk(words[2], w[3]);
    for (int j = 0; j < 3; j++) chk(16'(idxs[j]), 16'(a[5:0]));
    $display("page buffer test done");
    read_data_i = 8'($urandom);
    u_prg.oe(1'b0);
    u_prg.wait_n(8);
    chk(16'(data_oe_o), 16'h1);
    chk(16'(data_o), 16'(read_data_i));
    u_prg.oe(1'b1);
    u_prg.wait_n(8);
    chk(16'(data_oe_o), 16'h0);
    $display("read bus test done");
    final_report();
  end
endmodule
